// ==== hdl/qawd_pkg.sv ====
// Purpose: constants shared by the challenge/response watchdog
// Assumes: 100 MHz system clock
// Notes:   register offsets are byte addresses of the register port
package qawd_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG_ONE   = 8'h13;
    localparam logic [7:0] ADDR_CFG_TWO   = 8'h14;
    localparam logic [7:0] ADDR_KICK      = 8'h15;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h16;
    localparam logic [7:0] ADDR_CHAL_CFG  = 8'h2D;
    localparam logic [7:0] ADDR_RESP_WR   = 8'h2E;
    localparam logic [7:0] ADDR_CHAL_RD   = 8'h2F;
    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int         ERR_FLAG_BIT   = 6;
    localparam logic [7:0] CFG_ONE_RST    = 8'h50;
    localparam logic [7:0] CFG_TWO_RST    = 8'h00;
    localparam logic [3:0] THRESHOLD_RST  = 4'hF;
    localparam logic [3:0] SEED_RST       = 4'hA;
    localparam logic [1:0] ANS_CNT_START  = 2'h3;
    localparam logic [3:0] FAIL_CNT_MAX   = 4'hF;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          MS_NS          = 1000000;
    localparam logic [31:0] CYC_PER_MS_DEF = 32'(MS_NS / CLK_PERIOD_NS);
    // total window in ms from timer select and prescale select
    function automatic logic [14:0] win_total_ms(input logic [2:0] tmr,
                                                 input logic [1:0] pre);
        logic [14:0] base;
        base = 15'h0000;
        case (tmr)
            3'h0:    base = 15'd4;
            3'h1:    base = 15'd32;
            3'h2:    base = 15'd128;
            3'h3:    base = 15'd128;
            3'h4:    base = 15'd512;
            3'h5:    base = 15'd2048;
            default: base = 15'd10240;
        endcase
        if (tmr == 3'h3)
            win_total_ms = (pre == 2'h3) ? 15'd768 : 15'(base * (15'(pre) + 15'd2));
        else if (tmr >= 3'h6)
            win_total_ms = (pre == 2'h0) ? 15'd10240 : 15'd20240;
        else
            win_total_ms = 15'(base * (15'(pre) + 15'd1));
    endfunction
endpackage

// ==== hdl/qawd_chain.sv ====
// Purpose: 4-bit state chain that yields the challenge value
// Assumes: load has priority over step
// Notes:   a zero result is replaced by one so the chain never locks up
`timescale 1ns/1ns
`default_nettype none
module qawd_chain
    import qawd_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // control
    input  wire logic       load_i,
    input  wire logic [3:0] seed_i,
    input  wire logic       step_i,
    // result
    output var  logic [3:0] value_o
);
    logic [1:4] x;
    logic [1:4] next_x;
    logic [1:4] raw_x;

    // next state depends on present state only
    assign raw_x  = load_i ? {seed_i[3], seed_i[2], seed_i[1], seed_i[0]}
                           : {x[4] ^ x[3], x[1], x[2], x[3]};
    assign next_x = (raw_x == 4'h0) ? 4'h1 : raw_x;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            x <= SEED_RST;
        else if (load_i || step_i)
            x <= next_x;
    end

    assign value_o = {x[1], x[2], x[3], x[4]};
endmodule // qawd_chain
`default_nettype wire

// ==== hdl/qawd_answer_rom.sv ====
// Purpose: reference response bytes for each challenge value
// Assumes: default answer generation setting
// Notes:   pure lookup, no state
`timescale 1ns/1ns
`default_nettype none
module qawd_answer_rom
    import qawd_pkg::*;
(
    // selection
    input  wire logic [3:0] question_i,
    input  wire logic [1:0] count_i,
    // reference byte
    output var  logic [7:0] ref_o
);
    logic [31:0] row;

    // bytes ordered count 3 down to count 0
    always_comb
    begin
        row = 32'h0000_0000;
        case (question_i)
            4'h0:    row = 32'hFF0F_F000;
            4'h1:    row = 32'hB040_BF4F;
            4'h2:    row = 32'hE919_E616;
            4'h3:    row = 32'hA656_A959;
            4'h4:    row = 32'h7585_7A8A;
            4'h5:    row = 32'h3ACA_35C5;
            4'h6:    row = 32'h6393_6C9C;
            4'h7:    row = 32'h2CDC_23D3;
            4'h8:    row = 32'hD222_DD2D;
            4'h9:    row = 32'h9D6D_9262;
            4'hA:    row = 32'hC434_CB3B;
            4'hB:    row = 32'h8B7B_8474;
            4'hC:    row = 32'h58A8_57A7;
            4'hD:    row = 32'h17E7_18E8;
            4'hE:    row = 32'h4EBE_41B1;
            default: row = 32'h01F1_0EFE;
        endcase
    end

    assign ref_o = row[8*count_i +: 8];
endmodule // qawd_answer_rom
`default_nettype wire

// ==== hdl/qawd_core.sv ====
// Purpose: challenge/response watchdog sequencer with register port
// Assumes: register port accesses are single-cycle strobes
// Notes:   window timing counts whole milliseconds of the system clock
//
// Summary of operation
// - challenge comes from 4-bit state-only chain
// - challenge value readable anytime without side effects
// - chain steps when question counter wraps
// - failure trip clears counter, reloads seed
// - seed bits map onto chain state bits
// - zero chain value forced to one
// - standby seed write reloads chain only
// - byte counter starts each sequence at three
// - each write compared, counter counts down
// - after last byte, counter back to three
// - wrong byte sets error flag at once
// - error flag sticky, cleared by writing one
// - references from fixed sixteen-entry table
// - each response window is half total
// - failure action when count exceeds threshold
// - missing answers fail at window two end
// - under three in window one fails
// - good run decrements count, same question until counter wraps
// - four answers in window one fails
// - error flag ORs all error kinds
`timescale 1ns/1ns
`default_nettype none
module qawd_core
    import qawd_pkg::*;
#(
    parameter logic [31:0] CYC_PER_MS = CYC_PER_MS_DEF
)
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_we_i,
    input  wire logic       reg_re_i,
    output var  logic [7:0] reg_rdata_o,
    // device mode and failure action
    input  wire logic       standby_i,
    output var  logic       failure_o,
    output var  logic       qa_error_o
);
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_WIN1 = 2'b01,
        SEQ_WIN2 = 2'b11
    } qawd_seq_e;

    qawd_seq_e   state;
    qawd_seq_e   next_state;
    logic [7:0]  cfg_one;
    logic [2:0]  win_sel;
    logic [3:0]  fail_limit;
    logic [3:0]  seed;
    logic [3:0]  fail_cnt;
    logic [3:0]  qcnt;
    logic [1:0]  ans_cnt;
    logic [2:0]  w1_cnt;
    logic        val_bad;
    logic        qa_err;
    logic [31:0] tick_cnt;
    logic [14:0] ms_cnt;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic wr_cfg1;
    logic wr_cfg2;
    logic wr_kick;
    logic wr_thr;
    logic wr_qcfg;
    logic wr_ans;
    logic wr_qrd;
    assign wr_cfg1 = reg_we_i && (reg_addr_i == ADDR_CFG_ONE);
    assign wr_cfg2 = reg_we_i && (reg_addr_i == ADDR_CFG_TWO);
    assign wr_kick = reg_we_i && (reg_addr_i == ADDR_KICK);
    assign wr_thr  = reg_we_i && (reg_addr_i == ADDR_THRESHOLD);
    assign wr_qcfg = reg_we_i && (reg_addr_i == ADDR_CHAL_CFG);
    assign wr_ans  = reg_we_i && (reg_addr_i == ADDR_RESP_WR);
    assign wr_qrd  = reg_we_i && (reg_addr_i == ADDR_CHAL_RD);

    // ----------------------------------------------------------------
    // window timer
    // ----------------------------------------------------------------
    logic [14:0] total_ms;
    logic [14:0] half_ms;
    logic        ms_tick;
    logic        in_w1;
    logic        win_end;
    assign total_ms = win_total_ms(win_sel, cfg_one[5:4]);
    assign half_ms  = total_ms >> 1;
    assign ms_tick  = (tick_cnt == CYC_PER_MS - 32'd1);
    assign in_w1    = (state == SEQ_WIN1);
    assign win_end  = (state == SEQ_WIN2) && (ms_cnt >= total_ms);

    // ----------------------------------------------------------------
    // answer checking
    // ----------------------------------------------------------------
    logic [3:0] question;
    logic [7:0] ref_byte;
    logic       ans_wr;
    logic       match;
    logic       last;
    logic       seq_end;
    logic       early4;
    logic       good;
    logic       timeout;
    logic       fail_evt;
    logic       trip;
    logic       restart;
    logic       err_clr;
    logic       chain_load;
    logic       chain_step;

    qawd_answer_rom u_rom
    (
        .question_i (question),
        .count_i    (ans_cnt),
        .ref_o      (ref_byte)
    );

    // answers outside a running sequence are ignored
    assign ans_wr  = wr_ans && (state != SEQ_IDLE);
    assign match   = (reg_wdata_i == ref_byte);
    assign last    = (ans_cnt == 2'b00);
    assign seq_end = ans_wr && last;
    assign early4  = seq_end && in_w1;
    assign good    = seq_end && !in_w1 && match && !val_bad
                     && (w1_cnt == 3'd3);
    assign timeout = win_end && !seq_end;
    assign fail_evt = (seq_end && !good) || timeout;
    assign trip    = fail_evt && (fail_cnt >= fail_limit);
    assign restart = seq_end || timeout;
    assign err_clr = wr_qrd && reg_wdata_i[ERR_FLAG_BIT];
    assign chain_load = trip || (wr_qcfg && standby_i);
    assign chain_step = good && (qcnt == 4'hF);

    qawd_chain u_chain
    (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (chain_load),
        .seed_i    (wr_qcfg ? reg_wdata_i[3:0] : seed),
        .step_i    (chain_step),
        .value_o   (question)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            SEQ_IDLE: next_state = wr_kick ? SEQ_WIN1 : SEQ_IDLE;
            SEQ_WIN1: next_state = (ms_cnt >= half_ms) ? SEQ_WIN2 : SEQ_WIN1;
            SEQ_WIN2: next_state = SEQ_WIN2;
            default:  next_state = SEQ_IDLE;
        endcase
        if (restart || (wr_kick && state != SEQ_IDLE))
            next_state = SEQ_WIN1;
        if (trip)
            next_state = SEQ_IDLE;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state    <= SEQ_IDLE;
            tick_cnt <= 32'h0000_0000;
            ms_cnt   <= 15'h0000;
        end
        else
        begin
            state <= next_state;
            if (next_state != state || restart || wr_kick)
            begin
                tick_cnt <= 32'h0000_0000;
                ms_cnt   <= (next_state == SEQ_WIN2) ? ms_cnt : 15'h0000;
            end
            else if (ms_tick)
            begin
                tick_cnt <= 32'h0000_0000;
                ms_cnt   <= ms_cnt + 15'd1;
            end
            else
                tick_cnt <= tick_cnt + 32'd1;
        end
    end

    // byte counter and per-sequence tallies
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ans_cnt <= ANS_CNT_START;
            w1_cnt  <= 3'd0;
            val_bad <= 1'b0;
        end
        else if (restart || wr_kick || trip)
        begin
            ans_cnt <= ANS_CNT_START;
            w1_cnt  <= 3'd0;
            val_bad <= 1'b0;
        end
        else if (ans_wr)
        begin
            ans_cnt <= ans_cnt - 2'd1;
            w1_cnt  <= w1_cnt + {2'b00, in_w1};
            val_bad <= val_bad || !match;
        end
    end

    // sticky error flag, a new error wins over a clear
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            qa_err <= 1'b0;
        else if ((ans_wr && !match) || fail_evt)
            qa_err <= 1'b1;
        else if (err_clr)
            qa_err <= 1'b0;
    end

    // failure and question counters
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            fail_cnt  <= 4'h0;
            qcnt      <= 4'h0;
            failure_o <= 1'b0;
        end
        else
        begin
            failure_o <= trip;
            if (trip)
            begin
                fail_cnt <= 4'h0;
                qcnt     <= 4'h0;
            end
            else if (fail_evt)
                fail_cnt <= (fail_cnt == FAIL_CNT_MAX) ? fail_cnt : fail_cnt + 4'd1;
            else if (good)
            begin
                fail_cnt <= (fail_cnt == 4'h0) ? fail_cnt : fail_cnt - 4'd1;
                qcnt     <= qcnt + 4'd1;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration and read back
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr_i == ADDR_CFG_ONE)   ? cfg_one :
                    (reg_addr_i == ADDR_CFG_TWO)   ? {win_sel, 1'b0, fail_cnt} :
                    (reg_addr_i == ADDR_THRESHOLD) ? {4'h0, fail_limit} :
                    (reg_addr_i == ADDR_CHAL_CFG)  ? {4'h0, seed} :
                    (reg_addr_i == ADDR_CHAL_RD)   ? {1'b0, qa_err, ans_cnt, question} :
                    8'h00;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cfg_one     <= CFG_ONE_RST;
            win_sel     <= CFG_TWO_RST[7:5];
            fail_limit  <= THRESHOLD_RST;
            seed        <= SEED_RST;
            reg_rdata_o <= 8'h00;
            qa_error_o  <= 1'b0;
        end
        else
        begin
            if (wr_cfg1)
                cfg_one <= reg_wdata_i;
            if (wr_cfg2)
                win_sel <= reg_wdata_i[7:5];
            if (wr_thr)
                fail_limit <= reg_wdata_i[3:0];
            if (wr_qcfg)
                seed <= reg_wdata_i[3:0];
            if (reg_re_i)
                reg_rdata_o <= rd_mux;
            qa_error_o <= qa_err;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    AST_ANS_RESTART: assert property (seq_end |=> ans_cnt == 2'b11)
        else $error("byte counter not back to three");
    AST_ANS_DOWN: assert property (ans_wr && !last && !wr_kick && !timeout
        |=> ans_cnt == $past(ans_cnt) - 2'd1)
        else $error("byte counter did not count down");
    // the host may clear right after the bad byte, so the second cycle checks the output copy
    AST_ERR_SET: assert property (ans_wr && !match |=> qa_err ##1 qa_error_o)
        else $error("wrong byte did not raise error");
    AST_ERR_HOLD: assert property (qa_err && !err_clr |=> qa_err)
        else $error("error flag dropped without clear");
    AST_SAME_Q: assert property (fail_evt && !trip |=> $stable(question))
        else $error("question changed after failed run");
    AST_TRIP: assert property (trip |=> qcnt == 4'h0 && failure_o
        && state == SEQ_IDLE)
        else $error("trip did not reset sequence");
    AST_NONZERO: assert property (question != 4'h0)
        else $error("question reached zero");
    AST_EARLY: assert property (early4 && !trip && fail_cnt != FAIL_CNT_MAX
        |=> fail_cnt == $past(fail_cnt) + 4'd1 && qa_err)
        else $error("four answers in window one not failed");
    AST_TIMEOUT: assert property (timeout && !trip
        |=> state == SEQ_WIN1 && ans_cnt == 2'b11 && qa_err)
        else $error("window end did not restart");
    AST_GOOD: assert property (good && qcnt != 4'hF
        |=> $stable(question) && qcnt == $past(qcnt) + 4'd1)
        else $error("good run handled wrongly");

    COV_GOOD:    cover property (good);
    COV_EARLY:   cover property (early4);
    COV_TIMEOUT: cover property (timeout);
    COV_TRIP:    cover property (trip);
endmodule // qawd_core
`default_nettype wire

// ==== bench/qawd_host.sv ====
// Purpose: host model that drives the register port of the watchdog
// Assumes: signals change 1 ns after a rising edge
// Notes:   address and data wander while no strobe is up
`timescale 1ns/1ns
`default_nettype none
module qawd_host
    import qawd_pkg::*;
(
    // clock
    input  wire logic       clk_sys_i,
    // register port
    output var  logic [7:0] reg_addr_o,
    output var  logic [7:0] reg_wdata_o,
    output var  logic       reg_we_o,
    output var  logic       reg_re_o
);
    // ----------------------------------------------------------------
    // reference bytes, count 3 in the top byte down to count 0
    // ----------------------------------------------------------------
    localparam logic [31:0] TBL [16] = '{
        32'hFF0FF000, 32'hB040BF4F, 32'hE919E616, 32'hA656A959,
        32'h75857A8A, 32'h3ACA35C5, 32'h63936C9C, 32'h2CDC23D3,
        32'hD222DD2D, 32'h9D6D9262, 32'hC434CB3B, 32'h8B7B8474,
        32'h58A857A7, 32'h17E718E8, 32'h4EBE41B1, 32'h01F10EFE};

    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_we_o    = 1'b0;
        reg_re_o    = 1'b0;
    end

    // one strobe held over exactly one sampling edge
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_we_o    = w;
        reg_re_o    = ~w;
        @(posedge clk_sys_i);
        #1;
        reg_we_o    = 1'b0;
        reg_re_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask

    // first pre bytes at once, the rest after gap cycles; byte bad is spoilt
    task automatic seq(input logic [3:0] q, input int pre, input int gap, input int nb,
                       input int bad);
        logic [7:0] b;
        for (int i = 0; i < nb; i++)
        begin
            if (i == pre)
                repeat (gap) @(posedge clk_sys_i);
            b = TBL[q][8*(3-i) +: 8];
            if (i == bad)
                b = b ^ 8'($urandom_range(1, 255));
            acc(ADDR_RESP_WR, b, 1'b1);
        end
    endtask
    // window scaled down: 4 ms total stands in for the long host window
endmodule // qawd_host
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the challenge/response watchdog
// Assumes: 10 clocks stand for one millisecond
// Notes:   reads are noted in a queue and checked by a monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
    import qawd_pkg::*;
    logic       clk_sys   = 1'b0;
    logic       arst_n    = 1'b0;
    logic       standby   = 1'b0;
    logic       rd_d      = 1'b0;
    logic       err       = 1'b0;
    logic [3:0] q         = SEED_RST;
    logic [3:0] seed      = SEED_RST;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_we;
    logic       reg_re;
    logic [7:0] reg_rdata;
    logic       failure;
    logic       qa_error;
    logic [7:0] exp_q[$];
    int         n_fail    = 0;
    int         cmp_count = 0;
    int         n_trip    = 0;
    int         n_exp     = 0;
    int         fc        = 0;
    int         qc        = 0;
    int         thr       = 15;
    int         cp[3]     = '{4, 2, 3};
    int         cg[3]     = '{0, 20, 18};
    int         cb[3]     = '{-1, -1, 3};

    qawd_host qawd_host_i (
        .clk_sys_i   (clk_sys),
        .reg_addr_o  (reg_addr),
        .reg_wdata_o (reg_wdata),
        .reg_we_o    (reg_we),
        .reg_re_o    (reg_re)
    );
    qawd_core #(.CYC_PER_MS(32'h0000000A)) qawd_core_i (
        .clk_sys_i   (clk_sys),
        .arst_n_i    (arst_n),
        .reg_addr_i  (reg_addr),
        .reg_wdata_i (reg_wdata),
        .reg_we_i    (reg_we),
        .reg_re_i    (reg_re),
        .reg_rdata_o (reg_rdata),
        .standby_i   (standby),
        .failure_o   (failure),
        .qa_error_o  (qa_error)
    );

    always #5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge clk_sys)
    begin
        rd_d <= reg_re;
        if (rd_d)
            chk(reg_rdata, exp_q.pop_front());
        if (failure === 1'b1)
            n_trip++;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end

    // ----------------------------------------------------------------
    // host actions and the model of the expected state
    // ----------------------------------------------------------------
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        qawd_host_i.acc(a, 8'h00, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        qawd_host_i.acc(a, d, 1'b1);
    endtask

    function automatic logic [3:0] step(input logic [3:0] s);
        step = {s[0] ^ s[1], s[3], s[2], s[1]};
        if (step == 4'h0)
            step = 4'h1;
    endfunction

    task automatic status();
        rd(ADDR_CFG_TWO, {4'h0, 4'(fc)});
        rd(ADDR_CHAL_RD, {1'b0, err, 2'h3, q});
    endtask

    task automatic good();
        qawd_host_i.seq(q, 3, 18, 4, -1);
        fc = (fc == 0) ? 0 : fc - 1;
        qc = (qc + 1) % 16;
        if (qc == 0)
            q = step(q);
        status();
    endtask

    task automatic fail(input int p, input int g, input int n, input int b);
        logic trip;
        qawd_host_i.seq(q, p, g, n, b);
        if (n < 4)
            repeat (45) @(posedge clk_sys);
        trip = (fc >= thr);
        if (trip)
        begin
            fc = 0;
            qc = 0;
            q = seed;
            n_exp++;
            wr(ADDR_CHAL_RD, 8'h40);
            err = 1'b0;
        end
        else
        begin
            fc = (fc < 15) ? fc + 1 : 15;
            err = 1'b1;
        end
        status();
        wr(ADDR_CHAL_RD, 8'h40);
        err = 1'b0;
        rd(ADDR_CHAL_RD, {1'b0, err, 2'h3, q});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h6485));
        repeat (20) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        rd(ADDR_CFG_ONE, CFG_ONE_RST);
        rd(ADDR_CFG_TWO, CFG_TWO_RST);
        rd(ADDR_THRESHOLD, {4'h0, THRESHOLD_RST});
        rd(ADDR_CHAL_CFG, {4'h0, SEED_RST});
        rd(ADDR_CHAL_RD, {2'h0, ANS_CNT_START, SEED_RST});
        rd(8'h30 + 8'($urandom_range(0, 15)), 8'h00);
        wr(ADDR_CFG_ONE, 8'h40);
        rd(ADDR_CFG_ONE, 8'h40);
        $display("test reset done");
        wr(ADDR_KICK, 8'hFF);
        qawd_host_i.seq(q, 9, 0, 2, 1);
        rd(ADDR_CHAL_RD, {2'h1, 2'h1, q});
        chk({7'h00, qa_error}, 8'h01);
        fail(9, 0, 0, -1);
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_KICK, 8'hFF);
            fail(cp[k], cg[k], 4, cb[k]);
        end
        $display("test failures done");
        wr(ADDR_KICK, 8'hFF);
        for (int k = 0; k < 16; k++)
            good();
        $display("test good runs done");
        wr(ADDR_THRESHOLD, 8'h01);
        thr = 1;
        rd(ADDR_THRESHOLD, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_KICK, 8'hFF);
            fail(4, 0, 4, -1);
        end
        qawd_host_i.seq(q, 9, 0, 1, -1);
        rd(ADDR_CHAL_RD, {2'h0, 2'h3, q});
        $display("test trip done");
        wr(ADDR_CHAL_CFG, 8'h05);
        seed = 4'h5;
        rd(ADDR_CHAL_CFG, {4'h0, seed});
        rd(ADDR_CHAL_RD, {2'h0, 2'h3, q});
        standby = 1'b1;
        wr(ADDR_CHAL_CFG, 8'h05);
        q = 4'h5;
        rd(ADDR_CHAL_RD, {2'h0, 2'h3, q});
        standby = 1'b0;
        wr(ADDR_CFG_TWO, 8'hE7);
        rd(ADDR_CFG_TWO, 8'hE0);
        repeat (3) @(posedge clk_sys);
        chk(8'(n_trip), 8'(n_exp));
        chk(8'(exp_q.size()), 8'h00);
        $display("test seed done");
        conclude();
    end
endmodule // tb
`default_nettype wire
